// *** verilog/pgp_top.sv ***
// port pin block: four 8-bit ports with per-pin driver modes over AXI4-Lite
// assumes synchronous pin inputs, one clock mclk and an external pull-up per pin
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pgp_map.svh"

// Summary of operation
// - four 8-bit data registers, each bit tied to its own port pin.
// - port 0 pin x mode comes from bit x of both mode registers.
// - code high,low: 00 open-drain, 01 quasi, 10 high-impedance, 11 push-pull.
// - port 1 pins configured the same way by their own register pair.
// - ports 2 and 3 configured the same way by their own pairs.
module pgp_top #(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // axi write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // port 0 pins
  input  wire logic [PORT_W-1:0] port0_pin_in,
  output logic      [PORT_W-1:0] port0_pin_out,
  output logic      [PORT_W-1:0] port0_pin_oe_n,
  // port 1 pins
  input  wire logic [PORT_W-1:0] port1_pin_in,
  output logic      [PORT_W-1:0] port1_pin_out,
  output logic      [PORT_W-1:0] port1_pin_oe_n,
  // port 2 pins
  input  wire logic [PORT_W-1:0] port2_pin_in,
  output logic      [PORT_W-1:0] port2_pin_out,
  output logic      [PORT_W-1:0] port2_pin_oe_n,
  // port 3 pins
  input  wire logic [PORT_W-1:0] port3_pin_in,
  output logic      [PORT_W-1:0] port3_pin_out,
  output logic      [PORT_W-1:0] port3_pin_oe_n
);

  localparam int NPORT = 4;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (PORT_W < 1 || PORT_W > 32) begin : g_bad_width
      $error("PORT_W must lie in 1..32");
    end
    // decode slices the low eight address bits
    if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8 for the register map");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // storage and pin arrays
  // ----------------------------------------------------------------------
  logic [PORT_W-1:0] port_data_q [NPORT];
  logic [PORT_W-1:0] mode_low_q  [NPORT];
  logic [PORT_W-1:0] mode_high_q [NPORT];
  logic [PORT_W-1:0] pin_in_a    [NPORT];
  logic [PORT_W-1:0] pin_out_a   [NPORT];
  logic [PORT_W-1:0] pin_oe_n_a  [NPORT];
  logic [PORT_W-1:0] rd_val_a    [NPORT];

  logic [ADDR_W-1:0] wr_addr_q;
  logic [PORT_W-1:0] wr_data_q;
  logic              wr_strb_q;
  logic              wr_go;
  logic              aw_fire;
  logic              w_fire;
  logic              ar_fire;

  // address to register kind and port index
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] off;
    off = a[7:0];
    if (a[ADDR_W-1:0] >= ADDR_W'(`PGP_ADDR_SPAN) || off[1:0] != 2'h0) begin
      decode = {pgp_pkg::PGP_KIND_NONE, 2'h0};
    end else if (off >= `PGP_MODE_HIGH_BASE) begin
      decode = {pgp_pkg::PGP_KIND_HIGH, off[3:2]};
    end else if (off >= `PGP_MODE_LOW_BASE) begin
      decode = {pgp_pkg::PGP_KIND_LOW, off[3:2]};
    end else begin
      decode = {pgp_pkg::PGP_KIND_DATA, off[3:2]};
    end
  endfunction

  logic [3:0] wr_dec;
  logic [3:0] rd_dec;
  assign wr_dec  = decode(wr_addr_q);
  assign rd_dec  = decode(s_axi_araddr);
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  // both halves held and no response pending
  assign wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  // ----------------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------------
  // address and data taken in either order, readies close while held
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PGP_RESP_OKAY;
      wr_addr_q     <= '0;
      wr_data_q     <= '0;
      wr_strb_q     <= 1'b0;
    end else begin
      if (aw_fire) begin
        s_axi_awready <= 1'b0;
        wr_addr_q     <= s_axi_awaddr;
      end
      if (w_fire) begin
        s_axi_wready <= 1'b0;
        wr_data_q    <= s_axi_wdata[PORT_W-1:0];
        wr_strb_q    <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_dec[3:2] == pgp_pkg::PGP_KIND_NONE) ? `PGP_RESP_SLVERR : `PGP_RESP_OKAY;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file update on a committed write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < NPORT; p++) begin
        port_data_q[p] <= PORT_W'(`PGP_DATA_RST);
        mode_low_q[p]  <= PORT_W'(`PGP_MODE_RST);
        mode_high_q[p] <= PORT_W'(`PGP_MODE_RST);
      end
    end else if (wr_go && wr_strb_q) begin
      case (pgp_pkg::pgp_kind_t'(wr_dec[3:2]))
        pgp_pkg::PGP_KIND_DATA: port_data_q[wr_dec[1:0]] <= wr_data_q;
        pgp_pkg::PGP_KIND_LOW:  mode_low_q[wr_dec[1:0]]  <= wr_data_q;
        pgp_pkg::PGP_KIND_HIGH: mode_high_q[wr_dec[1:0]] <= wr_data_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // axi read channels
  // ----------------------------------------------------------------------
  // one read under way, data registered one cycle after the address
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PGP_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `PGP_RESP_OKAY;
      case (pgp_pkg::pgp_kind_t'(rd_dec[3:2]))
        pgp_pkg::PGP_KIND_DATA: s_axi_rdata <= 32'(rd_val_a[rd_dec[1:0]]);
        pgp_pkg::PGP_KIND_LOW:  s_axi_rdata <= 32'(mode_low_q[rd_dec[1:0]]);
        pgp_pkg::PGP_KIND_HIGH: s_axi_rdata <= 32'(mode_high_q[rd_dec[1:0]]);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `PGP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers, one per port
  // ----------------------------------------------------------------------
  assign pin_in_a[0]    = port0_pin_in;
  assign pin_in_a[1]    = port1_pin_in;
  assign pin_in_a[2]    = port2_pin_in;
  assign pin_in_a[3]    = port3_pin_in;
  assign port0_pin_out  = pin_out_a[0];
  assign port1_pin_out  = pin_out_a[1];
  assign port2_pin_out  = pin_out_a[2];
  assign port3_pin_out  = pin_out_a[3];
  assign port0_pin_oe_n = pin_oe_n_a[0];
  assign port1_pin_oe_n = pin_oe_n_a[1];
  assign port2_pin_oe_n = pin_oe_n_a[2];
  assign port3_pin_oe_n = pin_oe_n_a[3];

  generate
    for (genvar g = 0; g < NPORT; g++) begin : g_port
      pgp_pad #(
        .WIDTH     (PORT_W)
      ) u_pad (
        .clk       (mclk),
        .rst       (sys_rst),
        .mode_low  (mode_low_q[g]),
        .mode_high (mode_high_q[g]),
        .data      (port_data_q[g]),
        .pin_in    (pin_in_a[g]),
        .pin_out   (pin_out_a[g]),
        .pin_oe_n  (pin_oe_n_a[g]),
        .rd_val    (rd_val_a[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_data_write;
    @(posedge mclk) disable iff (sys_rst)
      (wr_go && wr_strb_q && wr_dec == 4'h0) |=> (port_data_q[0] == $past(wr_data_q));
  endproperty
  a_data_write: assert property (p_data_write) else $error("port 0 data write lost");

  property p_port1_push;
    @(posedge mclk) disable iff (sys_rst)
      1'b1 |=> (($past(mode_high_q[1] & mode_low_q[1]) & port1_pin_oe_n) == '0);
  endproperty
  a_port1_push: assert property (p_port1_push) else $error("port 1 push-pull pin released");

  property p_port3_hz;
    @(posedge mclk) disable iff (sys_rst)
      1'b1 |=> (($past(mode_high_q[3] & ~mode_low_q[3]) & ~port3_pin_oe_n) == '0);
  endproperty
  a_port3_hz: assert property (p_port3_hz) else $error("port 3 high-impedance pin driven");

  property p_bresp_once;
    @(posedge mclk) disable iff (sys_rst)
      wr_go |=> s_axi_bvalid ##1 (!s_axi_bvalid || !$past(s_axi_bready));
  endproperty
  a_bresp_once: assert property (p_bresp_once) else $error("write response not single");

  c_write: cover property (@(posedge mclk) disable iff (sys_rst) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge mclk) disable iff (sys_rst) s_axi_rvalid && s_axi_rready);
  c_port2_drive: cover property (@(posedge mclk) disable iff (sys_rst) |(~port2_pin_oe_n));

endmodule

`default_nettype wire

// *** verilog/pgp_map.svh ***
// register offsets, reset values and bus answers of the port pin block
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef PGP_MAP_SVH
`define PGP_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, port n adds 4*n)
// ----------------------------------------------------------------------
`define PGP_DATA_BASE      8'h00
`define PGP_MODE_LOW_BASE  8'h10
`define PGP_MODE_HIGH_BASE 8'h20
`define PGP_ADDR_SPAN      8'h30

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PGP_DATA_RST       8'hFF
`define PGP_MODE_RST       8'h00

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define PGP_RESP_OKAY      2'h0
`define PGP_RESP_SLVERR    2'h2

`endif

// *** verilog/pgp_pkg.sv ***
// types shared by the port pin block
// assumes nothing beyond a SystemVerilog compiler
package pgp_pkg;

  // pin driver mode, high bit from the high mode register
  typedef enum logic [1:0] {
    PGP_OPEN_DRAIN = 2'h0,
    PGP_QUASI      = 2'h1,
    PGP_HIGH_Z     = 2'h2,
    PGP_PUSH_PULL  = 2'h3
  } pgp_mode_t;

  // register kind selected by an address
  typedef enum logic [1:0] {
    PGP_KIND_DATA = 2'h0,
    PGP_KIND_LOW  = 2'h1,
    PGP_KIND_HIGH = 2'h2,
    PGP_KIND_NONE = 2'h3
  } pgp_kind_t;

endpackage

// *** verilog/pgp_pad.sv ***
// pin drivers of one port: mode decode, registered drive and read-back
// assumes pin inputs synchronous to clk and a board-level weak pull-up
`timescale 1ns/1ps
`default_nettype none

module pgp_pad #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // port registers
  input  wire logic [WIDTH-1:0] mode_low,
  input  wire logic [WIDTH-1:0] mode_high,
  input  wire logic [WIDTH-1:0] data,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  // value seen by a register read
  output logic      [WIDTH-1:0] rd_val
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] drive_d;
  logic [WIDTH-1:0] out_d;

  // refuse an empty port
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // per-bit mode decode
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // bit x of both mode registers forms the code
      case (pgp_pkg::pgp_mode_t'({mode_high[i], mode_low[i]}))
        pgp_pkg::PGP_OPEN_DRAIN: begin
          drive_d[i] = ~data[i];
          out_d[i]   = 1'b0;
        end
        pgp_pkg::PGP_QUASI: begin
          // strong high for one cycle on a rising data bit
          drive_d[i] = ~data[i] | ~prev_q[i];
          out_d[i]   = data[i];
        end
        pgp_pkg::PGP_HIGH_Z: begin
          drive_d[i] = 1'b0;
          out_d[i]   = 1'b0;
        end
        pgp_pkg::PGP_PUSH_PULL: begin
          drive_d[i] = 1'b1;
          out_d[i]   = data[i];
        end
        default: begin
          drive_d[i] = 1'b0;
          out_d[i]   = 1'b0;
        end
      endcase
      // pushed pins read the latch, all others the pin level
      rd_val[i] = (mode_high[i] & mode_low[i]) ? data[i] : pin_in[i];
    end
  end

  // registered drive toward the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
      prev_q   <= '1;
    end else begin
      pin_out  <= out_d;
      pin_oe_n <= ~drive_d;
      prev_q   <= data;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_od_mode;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((($past(~mode_high & ~mode_low & ~data)) & pin_oe_n) == '0)
               && ((($past(~mode_high & ~mode_low)) & ~pin_oe_n & pin_out) == '0);
  endproperty
  a_od_mode: assert property (p_od_mode) else $error("open-drain pin misdriven");

  property p_hz_mode;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (($past(mode_high & ~mode_low) & ~pin_oe_n) == '0);
  endproperty
  a_hz_mode: assert property (p_hz_mode) else $error("high-impedance pin driven");

  property p_pp_mode;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((($past(mode_high & mode_low)) & (pin_oe_n | (pin_out ^ $past(data)))) == '0);
  endproperty
  a_pp_mode: assert property (p_pp_mode) else $error("push-pull pin not following data");

  property p_readback;
    @(posedge clk) disable iff (rst)
      (((rd_val ^ pin_in) & ~mode_low) == '0)
      && (((rd_val ^ data) & mode_high & mode_low) == '0);
  endproperty
  a_readback: assert property (p_readback) else $error("released pin read wrong");

  c_quasi_pulse: cover property (@(posedge clk) disable iff (rst)
    (|(mode_low & ~mode_high & ~pin_oe_n & pin_out)));

endmodule

`default_nettype wire

// *** verif/pgp_board.sv ***
// board model on the port pins: weak pull-up, optional external pull-down
// assumes active low output enables from the port block
`timescale 1ns/1ps
`default_nettype none

module pgp_board #(
  parameter int W = 32
) (
  // pin drive from the port block
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  // board pulls a released pin low where set
  input  wire logic [W-1:0] ext_low,
  // resolved pin level
  output logic      [W-1:0] pin_lvl
);
  // released pins see the pull-up unless pulled low
  assign pin_lvl = (pin_oe_n & ~ext_low) | (~pin_oe_n & pin_out);
endmodule

`default_nettype wire

// *** verif/tb.sv ***
// bench for the port pin block: bus tasks, scoreboard queues, board model
// assumes pgp_top with default widths and the register map header
`timescale 1ns/1ps
`default_nettype none
`include "pgp_map.svh"

module tb;
  logic        mclk, sys_rst, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, pin_chk, q_en;
  logic [7:0]  awa, ara, lo, hi, d, e;
  logic [31:0] wd, rdat, p_in, p_out, p_oe, ext_low, rnd;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, pin_port;
  logic [23:0] x;
  int          n_fail, compares, q_cnt;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [15:0] pq[$];

  // device under test
  pgp_top dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .port0_pin_in(p_in[7:0]), .port0_pin_out(p_out[7:0]), .port0_pin_oe_n(p_oe[7:0]),
    .port1_pin_in(p_in[15:8]), .port1_pin_out(p_out[15:8]), .port1_pin_oe_n(p_oe[15:8]),
    .port2_pin_in(p_in[23:16]), .port2_pin_out(p_out[23:16]), .port2_pin_oe_n(p_oe[23:16]),
    .port3_pin_in(p_in[31:24]), .port3_pin_out(p_out[31:24]), .port3_pin_oe_n(p_oe[31:24]));

  // board on all four ports
  pgp_board brd (.pin_out(p_out), .pin_oe_n(p_oe), .ext_low(ext_low), .pin_lvl(p_in));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // expected {oe_n, driven out, read value} per bit of one port
  function automatic logic [23:0] exp_pins(input logic [7:0] l, input logic [7:0] h, input logic [7:0] dd,
                                           input logic [7:0] ee);
    logic [7:0] oe, dv, rv;
    for (int i = 0; i < 8; i++) begin
      oe[i] = (h[i] & ~l[i]) | (~h[i] & dd[i]);
      dv[i] = h[i] & l[i] & dd[i];
      rv[i] = (h[i] & l[i]) ? dd[i] : (oe[i] & ~ee[i]);
      if (h[i] & l[i]) oe[i] = 1'b0;
    end
    return {oe, dv, rv};
  endfunction

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dd, input logic [3:0] s, input logic [1:0] er);
    int k;
    @(posedge mclk);
    bq.push_back(er);
    awa <= a;
    wd <= {24'h0, dd};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    if (k == 50) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] ex);
    int k;
    @(posedge mclk);
    rq.push_back(ex);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    if (k == 50) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic pins(input int p, input logic [15:0] ex);
    @(posedge mclk);
    pq.push_back(ex);
    pin_port <= 2'(p);
    pin_chk <= 1'b1;
    @(posedge mclk);
    pin_chk <= 1'b0;
  endtask

  // monitor: answers and pin snapshots against the oldest note
  always @(posedge mclk) begin
    if (rv && rr) check({rresp, rdat}, rq.pop_front());
    if (bv && br) check({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (pin_chk) check({18'h0, p_oe[8*pin_port+:8], p_out[8*pin_port+:8] & ~p_oe[8*pin_port+:8]},
                       {18'h0, pq.pop_front()});
    if (q_en && p_oe[7:0] == 8'h00 && p_out[7:0] == 8'hFF) q_cnt++;
  end

  initial begin
    {awv, wv, br, arv, rr, pin_chk, q_en} = '0;
    {awa, ara, wd, ws, pin_port, ext_low} = '0;
    n_fail = 0;
    compares = 0;
    q_cnt = 0;
    rnd = 32'hb220a675;
    sys_rst = 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset state, refused accesses, strobe gating
    for (int p = 0; p < 4; p++) begin
      pins(p, 16'hFF00);
      rd(8'(`PGP_DATA_BASE + 4 * p), {2'h0, 32'hFF});
      rd(8'(`PGP_MODE_LOW_BASE + 4 * p), 34'h0);
      rd(8'(`PGP_MODE_HIGH_BASE + 4 * p), 34'h0);
    end
    rd(`PGP_ADDR_SPAN, {`PGP_RESP_SLVERR, 32'h0});
    rd(8'h01, {`PGP_RESP_SLVERR, 32'h0});
    wr(`PGP_ADDR_SPAN, 8'h00, 4'h1, `PGP_RESP_SLVERR);
    wr(`PGP_MODE_HIGH_BASE, 8'hFF, 4'h0, `PGP_RESP_OKAY);
    rd(`PGP_MODE_HIGH_BASE, 34'h0);
    // every code on every port, then mixed per-bit codes
    for (int p = 0; p < 4; p++) begin
      for (int it = 0; it < 6; it++) begin
        rnd = xs(rnd);
        lo = (it < 4) ? {8{it[0]}} : rnd[7:0];
        hi = (it < 4) ? {8{it[1]}} : rnd[15:8];
        d = rnd[23:16];
        e = rnd[31:24];
        wr(8'(`PGP_MODE_LOW_BASE + 4 * p), lo, 4'h1, `PGP_RESP_OKAY);
        wr(8'(`PGP_MODE_HIGH_BASE + 4 * p), hi, 4'hF, `PGP_RESP_OKAY);
        wr(8'(`PGP_DATA_BASE + 4 * p), d, 4'h1, `PGP_RESP_OKAY);
        ext_low[8*p+:8] <= e;
        repeat (3) @(posedge mclk);
        x = exp_pins(lo, hi, d, e);
        pins(p, x[23:8]);
        rd(8'(`PGP_DATA_BASE + 4 * p), {26'h0, x[7:0]});
        rd(8'(`PGP_MODE_LOW_BASE + 4 * p), {26'h0, lo});
        rd(8'(`PGP_MODE_HIGH_BASE + 4 * p), {26'h0, hi});
      end
    end
    // quasi mode: rising data drives high for one cycle only
    wr(`PGP_MODE_LOW_BASE, 8'hFF, 4'h1, `PGP_RESP_OKAY);
    wr(`PGP_MODE_HIGH_BASE, 8'h00, 4'h1, `PGP_RESP_OKAY);
    wr(`PGP_DATA_BASE, 8'h00, 4'h1, `PGP_RESP_OKAY);
    q_en <= 1'b1;
    wr(`PGP_DATA_BASE, 8'hFF, 4'h1, `PGP_RESP_OKAY);
    repeat (4) @(posedge mclk);
    q_en <= 1'b0;
    @(posedge mclk);
    check(34'(q_cnt), 34'h1);
    pins(0, 16'hFF00);
    repeat (4) @(posedge mclk);
    check(34'(rq.size() + bq.size() + pq.size()), 34'h0);
    finish_test();
  end
endmodule

`default_nettype wire
